/* File: hdl/scc_pkg.sv */
package scc_pkg;
	// register indexes; byte address is four times the index
	localparam logic [5:0] SCC_IDX_CTRL_TWO = 6'h1B;
	localparam logic [5:0] SCC_IDX_STAT_ONE = 6'h1C;
	localparam logic [5:0] SCC_IDX_CTRL_ONE = 6'h20;
	localparam int SCC_ADR_W = 8;
	localparam int SCC_DAT_W = 32;
	localparam int SCC_REG_W = 8;
	localparam logic [7:0] SCC_CTRL_TWO_RST = 8'h00;
	localparam logic [7:0] SCC_CTRL_ONE_RST = 8'h00;
	// status bit positions
	localparam int SCC_ST_TX_BUFFER_EMPTY_FLAG = 7;
	localparam int SCC_ST_TC = 6;
	localparam int SCC_ST_RX_BUFFER_FULL_FLAG = 5;
	localparam int SCC_ST_IDLE = 4;
	// character and break lengths in bit times
	localparam logic [3:0] SCC_CHAR_BITS_8 = 4'hA;
	localparam logic [3:0] SCC_CHAR_BITS_9 = 4'hB;
	localparam logic [3:0] SCC_BRK_BITS_8 = 4'hA;
	localparam logic [3:0] SCC_BRK_BITS_9 = 4'hB;
	localparam logic [3:0] SCC_BRK_LONG_8 = 4'hD;
	localparam logic [3:0] SCC_BRK_LONG_9 = 4'hE;
	localparam int SCC_SYNC_STAGES = 2;
	// second control register fields, bit 7 first
	typedef struct packed {
		logic tx_empty_irq_en;
		logic tx_done_irq_en;
		logic rx_full_irq_en;
		logic idle_irq_en;
		logic tx_enable;
		logic rx_on;
		logic rx_standby_wait;
		logic queue_break_ctl;
	} scc_ctrl_two_t;
	// first control register fields, bit 7 first
	typedef struct packed {
		logic internal_loop_sel;
		logic spare6;
		logic rx_source_sel;
		logic char_length_sel;
		logic wake_sel;
		logic spare2;
		logic long_break_sel;
		logic single_wire_dir;
	} scc_ctrl_one_t;
	// status flags, bit 7 first; low nibble comes from the receiver
	typedef struct packed {
		logic tx_buffer_empty_flag;
		logic tx_complete_flag;
		logic rx_buffer_full_flag;
		logic idle_flag;
		logic [3:0] rx_errors;
	} scc_stat_one_t;
endpackage

/* File: hdl/scc_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser for pin inputs
module scc_sync import scc_pkg::*; #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	// first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
		end else begin
			meta_reg <= d_i;
			sync_reg <= meta_reg;
		end
	end
	assign q_o = sync_reg;
endmodule
`default_nettype wire

/* File: hdl/scc_ctrl.sv */
// Function
// - control two always accessible, resets zero
// - tx empty flag interrupts when enabled
// - tx complete flag interrupts when enabled
// - rx full flag interrupts when enabled
// - idle flag interrupts when enabled
// - tx enable runs transmitter, owns pin
// - single wire direction follows dir bit
// - enable off then on queues idle while tx not complete
// - pin held until pending traffic finishes
// - rx off releases receive pin
// - loop mode releases receive pin
// - standby wait until selected wake condition
// - hardware clears standby on wake
// - break bit one then zero queues break
// - breaks repeat while set, length selectable
// - status flags read only, writes ignored
// - loop mode feeds tx into rx
// - tx empty set at reset, on load
// - idle after one high character time
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module scc_ctrl import scc_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [SCC_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [SCC_DAT_W-1:0] wb_dat_i,
	output logic [SCC_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic tx_serial_i,
	input wire logic tx_busy_i,
	input wire logic tx_load_i,
	input wire logic tx_data_wr_i,
	input wire logic idle_done_i,
	input wire logic brk_done_i,
	input wire logic rx_char_done_i,
	input wire logic rx_msb_i,
	input wire logic [3:0] rx_errors_i,
	input wire logic rx_data_rd_i,
	input wire logic bit_tick_i,
	input wire logic txd_pin_i,
	input wire logic rxd_pin_i,
	output logic txd_o,
	output logic txd_oe_o,
	output logic rxd_used_o,
	output logic rx_serial_o,
	output logic tx_run_o,
	output logic rx_run_o,
	output logic idle_req_o,
	output logic brk_req_o,
	output logic [3:0] brk_bits_o,
	output logic irq_o
);
	scc_ctrl_two_t c2_reg, c2_next;
	scc_ctrl_one_t c1_reg;
	scc_stat_one_t st_w;
	logic ack_reg, tx_buffer_empty_flag_reg, rx_buffer_full_flag_reg, idle_reg;
	logic tx_buffer_empty_flag_arm_reg, rx_buffer_full_flag_arm_reg, idle_arm_reg;
	logic idle_pend_reg, brk_pend_reg, own_reg, idle_ok_reg, seen_reg;
	logic [3:0] idle_cnt_reg;
	logic [SCC_DAT_W-1:0] rd_reg;
	logic [1:0] pins_s;
	logic txd_s, rxd_s;

	// pins pass two flops before use
	scc_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({txd_pin_i, rxd_pin_i}),
		.q_o(pins_s)
	);
	assign txd_s = pins_s[1];
	assign rxd_s = pins_s[0];

	// bus decode
	wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire [5:0] idx = wb_adr_i[7:2];
	wire hit_c2 = idx == SCC_IDX_CTRL_TWO;
	wire hit_c1 = idx == SCC_IDX_CTRL_ONE;
	wire hit_st = idx == SCC_IDX_STAT_ONE;
	wire wr_c2 = req & wb_we_i & wb_sel_i[0] & hit_c2;
	wire wr_c1 = req & wb_we_i & wb_sel_i[0] & hit_c1;
	wire rd_st = req & ~wb_we_i & hit_st;
	wire [7:0] wval = wb_dat_i[7:0];
	scc_ctrl_two_t wc2;
	assign wc2 = scc_ctrl_two_t'(wval);

	// mode decode
	wire loop = c1_reg.internal_loop_sel;
	wire single = loop & c1_reg.rx_source_sel;
	wire [3:0] char_bits = c1_reg.char_length_sel ? SCC_CHAR_BITS_9 : SCC_CHAR_BITS_8;
	wire tx_en_rise = wr_c2 & ~c2_reg.tx_enable & wc2.tx_enable;
	wire tx_en_fall = wr_c2 & c2_reg.tx_enable & ~wc2.tx_enable;
	wire brk_rise = wr_c2 & ~c2_reg.queue_break_ctl & wc2.queue_break_ctl;
	wire tc = tx_buffer_empty_flag_reg & ~tx_busy_i & ~idle_pend_reg & ~brk_pend_reg;

	// receive source: internal loop, shared tx pin, or rx pin
	assign rx_serial_o = single ? txd_s : (loop ? tx_serial_i : rxd_s);
	wire idle_det = seen_reg & bit_tick_i & rx_serial_o & (idle_cnt_reg == char_bits - 4'h1);
	wire wake = c1_reg.wake_sel ? (rx_char_done_i & rx_msb_i) : idle_det;

	// control two next value; standby clear overrides stored bit
	always_comb begin
		c2_next = c2_reg;
		if (wr_c2) begin
			c2_next = wc2;
		end
		if (c2_reg.rx_standby_wait & wake) begin
			c2_next.rx_standby_wait = 1'b0;
		end
	end

	// registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c2_reg <= scc_ctrl_two_t'(SCC_CTRL_TWO_RST);
			c1_reg <= scc_ctrl_one_t'(SCC_CTRL_ONE_RST);
		end else begin
			c2_reg <= c2_next;
			if (wr_c1) begin
				c1_reg <= scc_ctrl_one_t'(wval);
			end
		end
	end

	// bus answer one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rd_reg <= '0;
		end else begin
			ack_reg <= req;
			if (req & ~wb_we_i) begin
				rd_reg <= '0;
				if (hit_c2) rd_reg[7:0] <= c2_reg;
				if (hit_c1) rd_reg[7:0] <= c1_reg;
				if (hit_st) rd_reg[7:0] <= st_w;
			end
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rd_reg;

	// status; writes to it are never decoded
	assign st_w = '{tx_buffer_empty_flag_reg, tc, rx_buffer_full_flag_reg, idle_reg, rx_errors_i};

	// tx empty: read with flag then data write clears, load sets
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_buffer_empty_flag_reg <= 1'b1;
			tx_buffer_empty_flag_arm_reg <= 1'b0;
		end else begin
			if (rd_st & tx_buffer_empty_flag_reg) tx_buffer_empty_flag_arm_reg <= 1'b1;
			else if (tx_data_wr_i) tx_buffer_empty_flag_arm_reg <= 1'b0;
			if (tx_load_i) tx_buffer_empty_flag_reg <= 1'b1;
			else if (tx_data_wr_i & tx_buffer_empty_flag_arm_reg) tx_buffer_empty_flag_reg <= 1'b0;
		end
	end

	// rx full and idle: read with flag then data read clears
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_buffer_full_flag_reg <= 1'b0;
			idle_reg <= 1'b0;
			rx_buffer_full_flag_arm_reg <= 1'b0;
			idle_arm_reg <= 1'b0;
		end else begin
			if (rd_st) begin
				rx_buffer_full_flag_arm_reg <= rx_buffer_full_flag_reg;
				idle_arm_reg <= idle_reg;
			end else if (rx_data_rd_i) begin
				rx_buffer_full_flag_arm_reg <= 1'b0;
				idle_arm_reg <= 1'b0;
			end
			if (rx_char_done_i & rx_run_o) rx_buffer_full_flag_reg <= 1'b1;
			else if (rx_data_rd_i & rx_buffer_full_flag_arm_reg) rx_buffer_full_flag_reg <= 1'b0;
			if (idle_det & idle_ok_reg & rx_run_o) idle_reg <= 1'b1;
			else if (rx_data_rd_i & idle_arm_reg) idle_reg <= 1'b0;
		end
	end

	// idle counter: bit times of high line after activity
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_cnt_reg <= '0;
			seen_reg <= 1'b0;
			idle_ok_reg <= 1'b0;
		end else begin
			if (~rx_serial_o) begin
				idle_cnt_reg <= '0;
				seen_reg <= 1'b1;
			end else if (idle_det) begin
				idle_cnt_reg <= '0;
				seen_reg <= 1'b0;
			end else if (bit_tick_i & seen_reg) begin
				idle_cnt_reg <= idle_cnt_reg + 4'h1;
			end
			if (rx_char_done_i) idle_ok_reg <= 1'b1;
			else if (idle_det) idle_ok_reg <= 1'b0;
		end
	end

	// queued idle and break requests, pin ownership
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idle_pend_reg <= 1'b0;
			brk_pend_reg <= 1'b0;
			own_reg <= 1'b0;
		end else begin
			if (tx_en_rise & ~tc) idle_pend_reg <= 1'b1;
			else if (idle_done_i) idle_pend_reg <= 1'b0;
			if (brk_rise) brk_pend_reg <= 1'b1;
			else if (brk_done_i) brk_pend_reg <= c2_reg.queue_break_ctl;
			if (c2_reg.tx_enable) own_reg <= 1'b1;
			else if (tc) own_reg <= 1'b0;
		end
	end

	// transmitter pin and run controls
	assign tx_run_o = own_reg | c2_reg.tx_enable;
	assign txd_o = tx_serial_i;
	assign txd_oe_o = tx_run_o & (~single | c1_reg.single_wire_dir);
	assign rxd_used_o = c2_reg.rx_on & ~loop;
	assign rx_run_o = c2_reg.rx_on & ~c2_reg.rx_standby_wait;
	assign idle_req_o = idle_pend_reg;
	assign brk_req_o = brk_pend_reg;
	assign brk_bits_o = c1_reg.long_break_sel ?
		(c1_reg.char_length_sel ? SCC_BRK_LONG_9 : SCC_BRK_LONG_8) :
		(c1_reg.char_length_sel ? SCC_BRK_BITS_9 : SCC_BRK_BITS_8);

	// one level request from all enabled sources
	assign irq_o = (c2_reg.tx_empty_irq_en & tx_buffer_empty_flag_reg) | (c2_reg.tx_done_irq_en & tc)
		| (c2_reg.rx_full_irq_en & rx_buffer_full_flag_reg) | (c2_reg.idle_irq_en & idle_reg);

	// checks
	sequence brk_set_s;
		wr_c2 & wc2.queue_break_ctl & ~c2_reg.queue_break_ctl;
	endsequence
	sequence brk_clr_s;
		wr_c2 & ~wc2.queue_break_ctl;
	endsequence
	reset_zero_a: assert property (@(posedge clk_i) rst_i |=> c2_reg == '0 && tx_buffer_empty_flag_reg)
		else $error("control two not zero after reset");
	tx_buffer_empty_flag_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
		c2_reg.tx_empty_irq_en & tx_buffer_empty_flag_reg |-> irq_o) else $error("tx empty irq missing");
	tc_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
		c2_reg.tx_done_irq_en & st_w.tx_complete_flag |-> irq_o) else $error("tc irq missing");
	rx_buffer_full_flag_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
		c2_reg.rx_full_irq_en & rx_buffer_full_flag_reg |-> irq_o) else $error("rx full irq missing");
	idle_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
		c2_reg.idle_irq_en & idle_reg |-> irq_o) else $error("idle irq missing");
	irq_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
		c2_reg[7:4] == 4'h0 |-> ~irq_o) else $error("irq with no enable");
	tx_own_a: assert property (@(posedge clk_i) disable iff (rst_i)
		c2_reg.tx_enable & ~single |-> txd_oe_o) else $error("tx pin not driven");
	wire_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
		single & ~c1_reg.single_wire_dir |-> ~txd_oe_o) else $error("single wire dir ignored");
	idle_queue_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_en_rise & ~tc & ~idle_done_i |=> idle_req_o) else $error("idle not queued");
	tx_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_en_fall & brk_pend_reg & ~single |=> txd_oe_o) else $error("pin dropped early");
	rx_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
		~c2_reg.rx_on | loop |-> ~rxd_used_o) else $error("rx pin held");
	standby_a: assert property (@(posedge clk_i) disable iff (rst_i)
		c2_reg.rx_standby_wait & ~wake & ~wr_c2 |=> ~rx_run_o) else $error("rx ran in standby");
	wake_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		c2_reg.rx_standby_wait & wake |=> ~c2_reg.rx_standby_wait) else $error("standby kept");
	brk_queue_a: assert property (@(posedge clk_i) disable iff (rst_i)
		brk_set_s ##1 (~brk_done_i)[*3] ##0 brk_clr_s |=> brk_req_o)
		else $error("break not queued");
	brk_repeat_a: assert property (@(posedge clk_i) disable iff (rst_i)
		brk_done_i & c2_reg.queue_break_ctl |=> brk_req_o) else $error("break not repeated");
	stat_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req & wb_we_i & hit_st & ~tx_load_i & ~tx_data_wr_i & ~rx_char_done_i & ~rx_data_rd_i
		|=> $stable(rx_buffer_full_flag_reg) && $stable(tx_buffer_empty_flag_reg)) else $error("status changed by write");
	loop_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
		loop & ~single |-> rx_serial_o == tx_serial_i) else $error("loop path broken");
	tx_buffer_empty_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_load_i |=> tx_buffer_empty_flag_reg) else $error("tx empty not set");
	idle_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		idle_det & idle_ok_reg & rx_run_o |=> idle_reg) else $error("idle not set");
endmodule
`default_nettype wire

/* File: bench/scc_partner.sv */
`timescale 1ns/1ns
`default_nettype none
// transmit datapath stand-in: bit clock, one break or idle character at a time
module scc_partner (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic brk_req_i,
	input wire logic idle_req_i,
	input wire logic [3:0] brk_bits_i,
	output logic bit_tick_o,
	output logic brk_done_o,
	output logic idle_done_o,
	output logic tx_busy_o,
	output logic tx_serial_o
);
	logic [1:0] div_reg;
	logic [3:0] bits_reg;
	logic brk_reg;
	// one bit time is four clocks; break holds the line low
	assign bit_tick_o = (div_reg == 2'h3);
	assign tx_serial_o = !(tx_busy_o && brk_reg);
	// count a character down, then pulse its done strobe
	always_ff @(posedge clk_i) begin
		div_reg <= div_reg + 2'h1;
		brk_done_o <= 1'b0;
		idle_done_o <= 1'b0;
		if (rst_i) begin
			div_reg <= 2'h0;
			tx_busy_o <= 1'b0;
			brk_reg <= 1'b0;
			bits_reg <= 4'h0;
		end else if (tx_busy_o) begin
			if (bit_tick_o) begin
				bits_reg <= bits_reg - 4'h1;
				if (bits_reg == 4'h1) begin
					tx_busy_o <= 1'b0;
					brk_done_o <= brk_reg;
					idle_done_o <= !brk_reg;
				end
			end
		end else if (!brk_done_o && !idle_done_o && (brk_req_i || idle_req_i)) begin
			tx_busy_o <= 1'b1;
			brk_reg <= brk_req_i;
			bits_reg <= brk_req_i ? brk_bits_i : 4'hA;
		end
	end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import scc_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, cdone = 0, msb = 0, drd = 0, rxd = 1;
	logic ld = 0, dwr = 0, txs_o;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0, errs = 4'h0, bits;
	logic [31:0] dat = 32'h0, dat_o, q;
	logic ack, txs, txd, oe, used, rxs, trun, rrun, ireq, breq, irq, tick, bdone, idone, busy;
	integer seed = 32'h5eab7fff, n_errors = 0, check_count = 0, cycles = 0, n_brk = 0, i, v;
	logic [7:0] c1t [4] = '{8'h00, 8'h10, 8'h02, 8'h12};
	logic [3:0] bt [4] = '{4'hA, 4'hB, 4'hD, 4'hE};
	scc_ctrl scc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .tx_serial_i(txs), .tx_busy_i(busy), .tx_load_i(ld),
		.tx_data_wr_i(dwr), .idle_done_i(idone), .brk_done_i(bdone), .rx_char_done_i(cdone),
		.rx_msb_i(msb), .rx_errors_i(errs), .rx_data_rd_i(drd), .bit_tick_i(tick),
		.txd_pin_i(txd), .rxd_pin_i(rxd), .txd_o(txs_o), .txd_oe_o(oe), .rxd_used_o(used),
		.rx_serial_o(rxs), .tx_run_o(trun), .rx_run_o(rrun), .idle_req_o(ireq),
		.brk_req_o(breq), .brk_bits_o(bits), .irq_o(irq));
	scc_partner scc_partner_i (.clk_i(clk_i), .rst_i(rst_i), .brk_req_i(breq),
		.idle_req_i(ireq), .brk_bits_i(bits), .bit_tick_o(tick), .brk_done_o(bdone),
		.idle_done_o(idone), .tx_busy_o(busy), .tx_serial_o(txs));
	// tx pin has a pull-up when nobody drives it
	assign txd = oe ? txs_o : 1'b1;
	// clock, cycle ceiling and break count
	always #2 clk_i = !clk_i;
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (bdone === 1'b1)
			n_brk <= n_brk + 1;
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
			n_errors = n_errors + 1;
		end
	endtask
	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		sel <= s;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 0;
		stb <= 0;
		#1;
	endtask
	task automatic w(input integer n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic pulse_char(input logic m);
		@(posedge clk_i);
		cdone <= 1;
		msb <= m;
		@(posedge clk_i);
		cdone <= 0;
		#1;
	endtask
	initial begin
		errs = $random(seed);
		w(8);
		rst_i <= 0;
		w(2);
		wb(0, 8'h6C, 0, 4'hF); chk("ctrl2 reset", q, 0);
		wb(0, 8'h70, 0, 4'hF); chk("status reset", q, {4'hC, errs});
		wb(1, 8'h70, 8'h00, 4'hF); wb(0, 8'h70, 0, 4'hF);
		chk("status write", q, {4'hC, errs});
		wb(0, 8'hFC, 0, 4'hF); chk("unmapped", q, 0);
		for (i = 0; i < 8; i++) begin
			v = $random(seed) & 8'hF4;
			wb(1, 8'h6C, v, 4'hF); wb(1, 8'h6C, 8'hFF, 4'hE); wb(0, 8'h6C, 0, 4'hF);
			chk("ctrl2 rw", q, v);
			chk("irq mask", irq, v[7] | v[6]);
			chk("rx pin", used, v[2]);
		end
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			wb(1, 8'h80, c1t[i], 4'hF); w(1); chk("break len", bits, bt[i]);
		end
		wb(1, 8'h80, 8'h00, 4'hF);
		wb(1, 8'h6C, 8'h09, 4'hF); wb(1, 8'h6C, 8'h08, 4'hF);
		chk("tx own", {oe, trun}, 2'b11);
		wb(1, 8'h6C, 8'h00, 4'hF);
		chk("pin held", {oe, trun}, 2'b11);
		wb(1, 8'h6C, 8'h08, 4'hF); w(1); chk("idle queued", ireq, 1);
		wb(1, 8'h6C, 8'h00, 4'hF);
		for (i = 0; i < 400 && (ireq | breq | busy) !== 1'b0; i++)
			w(1);
		w(2);
		chk("pin freed", oe, 0);
		chk("break count", n_brk >= 1 && n_brk <= 2, 1);
		$display("test break and idle done");
		wb(1, 8'h6C, 8'h0C, 4'hF);
		foreach (c1t[i]) begin
			v = (i == 0) ? 8'h80 : (i == 1) ? 8'hA0 : 8'hA1;
			if (i < 3) begin
				wb(1, 8'h80, v, 4'hF); rxd <= 0; w(3);
				chk("loop rx pin", used, 0);
				chk("loop oe", oe, v[0] | !v[5]);
				chk("loop feed", rxs, 1);
			end
		end
		rxd <= 1;
		wb(1, 8'h80, 8'h08, 4'hF); wb(1, 8'h6C, 8'h06, 4'hF); w(1);
		chk("standby", rrun, 0);
		pulse_char(0); wb(0, 8'h6C, 0, 4'hF); chk("no wake", q, 8'h06);
		pulse_char(1); w(1); wb(0, 8'h6C, 0, 4'hF); chk("wake", q, 8'h04);
		chk("rx run", rrun, 1);
		wb(1, 8'h6C, 8'h24, 4'hF); pulse_char(0); w(1);
		wb(0, 8'h70, 0, 4'hF); chk("rx full", q, {4'hE, errs});
		chk("rx irq", irq, 1);
		@(posedge clk_i); drd <= 1; @(posedge clk_i); drd <= 0;
		wb(0, 8'h70, 0, 4'hF); chk("rx clear", q, {4'hC, errs});
		chk("rx irq off", irq, 0);
		@(posedge clk_i); dwr <= 1; @(posedge clk_i); dwr <= 0;
		wb(0, 8'h70, 0, 4'hF); chk("tx empty clear", q, {4'h0, errs});
		@(posedge clk_i); ld <= 1; @(posedge clk_i); ld <= 0;
		wb(0, 8'h70, 0, 4'hF); chk("tx empty load", q, {4'hC, errs});
		$display("test receiver done");
		wb(1, 8'h80, 8'h00, 4'hF); wb(1, 8'h6C, 8'h14, 4'hF);
		@(posedge clk_i); rxd <= 0; w(12); rxd <= 1;
		w(90); chk("idle irq", irq, 1);
		wb(0, 8'h70, 0, 4'hF); chk("idle flag", q, {4'hD, errs});
		$display("test idle done");
		close_out();
	end
endmodule
`default_nettype wire
